// *** src/sisl_cfg.svh ***
// Constants of the sensor interrupt and status logic.
// Assumes one 100 MHz system clock and a byte-wide register port.
//
// Behaviour
// RULE1: Map bits route each source to pin A, pin B or both; shared pins OR.
// RULE2: A pin with no mapped source is not driven.
// RULE3: Both pins are undriven while reset is low.
// RULE4: Reading a status register clears the sticky flags it holds.
// RULE5: Sample ready clears once every enabled axis has been read.
// RULE6: Buffer ready and overrun follow their live trigger conditions.
// RULE7: Threshold clears after drain, flag read and, on SPI, select release.
// RULE8: Pins are push-pull; keepers outside hold them when undriven.
// RULE9: Host disables a source while it reprograms that source.
// RULE10: A write while the memory is busy sets a sticky flag until read.
// RULE11: With parity enabled, a 100 Hz tick starts each parity pass.
// RULE12: A pass sums all writable bits; mismatch with the stored result errs.
// RULE13: Parity error sets a sticky and a live flag, both mappable.
// RULE14: Host resets the device after a parity error.
// RULE15: Memory error flag is the OR of fuse, correct-detect and checksum.
// RULE16: Memory error flags clear on a status read or reset.
// RULE17: Live overrange flag follows the input against the threshold.
// RULE18: Sticky overrange sets on any event and clears on its status read.
// RULE19: Config bit 3 disables detection and protection; bit 2 protection.
// RULE20: Overrange data is railed, held or passed as selected.
// RULE21: In PDM mode overrange data is always railed; the code passes it unrailed while config bit 2 is set.
// RULE22: An event in the cycle of its clearing read keeps the flag set.
// RULE23: A mapped pin drives high while its OR is true, else low.
`ifndef SISL_CFG_SVH
`define SISL_CFG_SVH

`define SISL_ADDR_EVST0 7'h11
`define SISL_ADDR_EVST1 7'h12
`define SISL_ADDR_EVST2 7'h13
`define SISL_ADDR_EVST3 7'h14
`define SISL_ADDR_DATA_X 7'h15
`define SISL_ADDR_DATA_LAST 7'h1A
`define SISL_ADDR_PARLIVE 7'h20
`define SISL_ADDR_PAREN 7'h27
`define SISL_ADDR_MAP_A_LO 7'h2B
`define SISL_ADDR_MAP_A_HI 7'h2C
`define SISL_ADDR_MAP_B_LO 7'h2D
`define SISL_ADDR_MAP_B_HI 7'h2E
`define SISL_ADDR_NVCHK 7'h29
`define SISL_ADDR_ORSET 7'h48

`define SISL_ST0_PARITY 0
`define SISL_ST0_ACT 1
`define SISL_ST0_INACT 2
`define SISL_ST0_THRESH 3
`define SISL_ST0_UVOLT 4
`define SISL_ST0_WRBUSY 5
`define SISL_ST0_STICKY_MASK 8'h37
`define SISL_ST1_OR_LIVE 3
`define SISL_ST1_OR_STICKY 4
`define SISL_ST1_NVM 7
`define SISL_ST2_ECC 5
`define SISL_ST2_CRC 3
`define SISL_ST3_SMP_RDY 0
`define SISL_PARLIVE_BIT 5
`define SISL_OR_DET_OFF 3
`define SISL_OR_PROT_OFF 2

`define SISL_RESET_BYTE 8'h00
`define SISL_OR_THRESH 16'h7F00
`define SISL_FULL_POS 16'h7FFF
`define SISL_FULL_NEG 16'h8000
`define SISL_PAR_LAST 3'h6
`define SISL_SYS_CLK_HZ 100000000
`define SISL_PARITY_TICK_HZ 100
`define SISL_TICK_CYCLES (`SISL_SYS_CLK_HZ / `SISL_PARITY_TICK_HZ)

`endif

// *** src/sisl_pkg.sv ***
// Types of the sensor interrupt and status logic.
// Assumes sisl_cfg.svh supplies all numeric constants.
`default_nettype none

package sisl_pkg;

	typedef enum logic [0:0] {
		PAR_IDLE = 1'b0,
		PAR_RUN = 1'b1
	} sisl_par_type;

	typedef enum logic [1:0] {
		OR_RAIL = 2'b00,
		OR_HOLD = 2'b01,
		OR_PASS = 2'b10
	} sisl_orpol_type;

	typedef struct packed {
		logic [15:0] map_a;
		logic [15:0] map_b;
		logic par_en;
		logic [7:0] nv_check_ctl;
		logic [7:0] or_setup;
		logic [7:0] st0;
		logic thr_pend;
		logic fuse_err;
		logic ecc_det;
		logic crc_err;
		logic or_sticky;
		logic sample_ready;
		logic [2:0] axis_rd;
		logic [19:0] tick_cnt;
		sisl_par_type par_state;
		logic [2:0] par_idx;
		logic par_acc;
		logic par_old;
		logic par_old_v;
		logic par_dirty;
		logic par_live;
		logic [7:0] rdata;
		logic pin_a;
		logic pin_b;
		logic [15:0] data_out;
		logic [15:0] last_good;
		logic cs_s1;
		logic cs_s2;
	} sisl_state_type;

endpackage : sisl_pkg

`default_nettype wire

// *** src/sisl_top.sv ***
// Interrupt routing, status flags, parity checker and overrange handling.
// Assumes event inputs come from logic on the same clock; only the chip
// select pin is asynchronous. Bus keepers on the pins sit outside.
`include "sisl_cfg.svh"
`default_nettype none

module sisl_top #(
	parameter int TICK_CYCLES = `SISL_TICK_CYCLES
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// Register port
	input wire logic [6:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [7:0] o_reg_rdata,
	// Serial port mode and chip select pin
	input wire logic i_spi_mode,
	input wire logic i_spi_cs_n,
	// Event sources
	input wire logic i_sample_new,
	input wire logic [2:0] i_axis_en,
	input wire logic i_buf_ready,
	input wire logic i_buf_overrun,
	input wire logic i_buf_above_thr,
	input wire logic i_activity,
	input wire logic i_inactivity,
	input wire logic i_undervolt,
	input wire logic i_nvm_busy,
	input wire logic i_fuse_err,
	input wire logic i_ecc_det,
	input wire logic i_crc_err,
	// Acceleration path
	input wire logic signed [15:0] i_accel,
	input wire logic i_pdm_mode,
	output logic [15:0] o_accel_data,
	// Memory control
	output logic [7:0] o_nv_check_ctl,
	// Interrupt pins
	output logic o_irq_pin_a,
	output logic o_irq_pin_a_oe,
	output logic o_irq_pin_b,
	output logic o_irq_pin_b_oe
);

	sisl_pkg::sisl_state_type s_reg;
	sisl_pkg::sisl_state_type s_next;

	localparam logic [19:0] TICK_LAST = 20'(TICK_CYCLES - 1);

	// One byte of the writable set per parity step
	function automatic logic [7:0] par_byte(
		input sisl_pkg::sisl_state_type st,
		input logic [2:0] idx
	);
		logic [7:0] b;
		b = 8'h00;
		unique case (idx)
			3'h0: b = st.map_a[7:0];
			3'h1: b = st.map_a[15:8];
			3'h2: b = st.map_b[7:0];
			3'h3: b = st.map_b[15:8];
			3'h4: b = {7'h00, st.par_en};
			3'h5: b = st.nv_check_ctl;
			3'h6: b = st.or_setup;
			default: b = 8'h00;
		endcase
		return b;
	endfunction : par_byte

	// Axis touched by a data register read, one-hot
	function automatic logic [2:0] axis_of(input logic [6:0] addr);
		logic [6:0] off;
		logic [2:0] hit;
		off = 7'(addr - `SISL_ADDR_DATA_X);
		hit = 3'h0;
		if (addr >= `SISL_ADDR_DATA_X && addr <= `SISL_ADDR_DATA_LAST) begin
			hit = 3'(3'h1 << off[2:1]);
		end
		return hit;
	endfunction : axis_of

	logic rd0;
	logic rd1;
	logic rd_any;
	logic [2:0] ax_rd;
	logic [2:0] ax_seen;
	logic nvm_flag;
	logic thr_irq;
	logic or_live;
	logic [15:0] src;
	logic [7:0] st0_set;
	logic [7:0] par_b;
	logic par_sum;
	logic par_err;
	logic [15:0] magnitude;
	logic [15:0] rail;
	sisl_pkg::sisl_orpol_type policy;

	always_comb begin
		s_next = s_reg;
		rd0 = i_reg_rd && i_reg_addr == `SISL_ADDR_EVST0;
		rd1 = i_reg_rd && i_reg_addr == `SISL_ADDR_EVST1;
		// Any status read also clears the memory error stickies
		rd_any = i_reg_rd && i_reg_addr >= `SISL_ADDR_EVST0
			&& i_reg_addr <= `SISL_ADDR_EVST3;
		ax_rd = i_reg_rd ? axis_of(i_reg_addr) : 3'h0;
		par_b = par_byte(s_reg, s_reg.par_idx);
		par_sum = s_reg.par_acc ^ (^par_b);
		par_err = 1'b0;

		// Chip select pin, two stages before use
		s_next.cs_s1 = i_spi_cs_n;
		s_next.cs_s2 = s_reg.cs_s1;

		// Register writes
		if (i_reg_wr) begin
			unique case (i_reg_addr)
				`SISL_ADDR_MAP_A_LO: s_next.map_a[7:0] = i_reg_wdata; // RULE1
				`SISL_ADDR_MAP_A_HI: s_next.map_a[15:8] = i_reg_wdata; // RULE1
				`SISL_ADDR_MAP_B_LO: s_next.map_b[7:0] = i_reg_wdata; // RULE1
				`SISL_ADDR_MAP_B_HI: s_next.map_b[15:8] = i_reg_wdata; // RULE1
				`SISL_ADDR_PAREN: s_next.par_en = i_reg_wdata[0]; // RULE11
				`SISL_ADDR_NVCHK: s_next.nv_check_ctl = i_reg_wdata;
				`SISL_ADDR_ORSET: s_next.or_setup = i_reg_wdata; // RULE19
				default: ;
			endcase
			// Any write, even to an unmapped address, drops the old result as no longer comparable
			s_next.par_old_v = 1'b0;
			s_next.par_dirty = 1'b1;
		end

		// Sticky flags: set wins over the clearing read
		st0_set = 8'h00;
		st0_set[`SISL_ST0_ACT] = i_activity;
		st0_set[`SISL_ST0_INACT] = i_inactivity;
		st0_set[`SISL_ST0_UVOLT] = i_undervolt;
		st0_set[`SISL_ST0_WRBUSY] = i_reg_wr && i_nvm_busy; // RULE10

		// Parity stepper, one writable byte per cycle
		unique case (s_reg.par_state)
			sisl_pkg::PAR_IDLE: begin
				if (s_reg.par_en && s_reg.tick_cnt == TICK_LAST) begin // RULE11
					s_next.par_state = sisl_pkg::PAR_RUN;
					s_next.par_idx = 3'h0;
					s_next.par_acc = 1'b0;
					s_next.par_dirty = i_reg_wr;
				end
			end
			sisl_pkg::PAR_RUN: begin
				s_next.par_acc = par_sum; // RULE12
				s_next.par_idx = 3'(s_reg.par_idx + 3'h1);
				if (s_reg.par_idx == `SISL_PAR_LAST) begin
					s_next.par_state = sisl_pkg::PAR_IDLE;
					if (!s_reg.par_dirty && !i_reg_wr) begin
						par_err = s_reg.par_old_v && par_sum != s_reg.par_old; // RULE12
						s_next.par_old = par_sum;
						s_next.par_old_v = 1'b1;
					end
				end
			end
		endcase
		st0_set[`SISL_ST0_PARITY] = par_err; // RULE13
		if (par_err) begin
			s_next.par_live = 1'b1; // RULE13
		end
		s_next.tick_cnt = (s_reg.tick_cnt == TICK_LAST) ? 20'h00000
			: 20'(s_reg.tick_cnt + 20'h00001);

		s_next.st0 = (s_reg.st0 & ~(rd0 ? `SISL_ST0_STICKY_MASK : 8'h00))
			| st0_set; // RULE4 RULE22

		// Buffer threshold: drain, read flag, then release select on SPI
		thr_irq = s_reg.st0[`SISL_ST0_THRESH];
		if (i_buf_above_thr) begin
			s_next.st0[`SISL_ST0_THRESH] = 1'b1; // RULE22
			s_next.thr_pend = 1'b0;
		end else begin
			if (rd0 && thr_irq) begin
				s_next.thr_pend = 1'b1; // RULE7
			end
			if (s_reg.thr_pend && (!i_spi_mode || s_reg.cs_s2)) begin
				s_next.st0[`SISL_ST0_THRESH] = 1'b0; // RULE7
				s_next.thr_pend = 1'b0;
			end else begin
				s_next.st0[`SISL_ST0_THRESH] = thr_irq;
			end
		end

		// Memory error flags clear on any status read
		s_next.fuse_err = (s_reg.fuse_err && !rd_any) || i_fuse_err; // RULE16
		s_next.ecc_det = (s_reg.ecc_det && !rd_any) || i_ecc_det; // RULE16
		s_next.crc_err = (s_reg.crc_err && !rd_any) || i_crc_err; // RULE16
		nvm_flag = s_reg.fuse_err || s_reg.ecc_det || s_reg.crc_err; // RULE15

		// Overrange detection and data policy
		// Full negative scale wraps to 8000, still above the threshold
		magnitude = i_accel[15] ? 16'(-i_accel) : i_accel;
		or_live = !s_reg.or_setup[`SISL_OR_DET_OFF]
			&& magnitude > `SISL_OR_THRESH; // RULE17 RULE19
		s_next.or_sticky = (s_reg.or_sticky && !rd1) || or_live; // RULE18
		// Policy code 11 falls to the default and passes data
		policy = sisl_pkg::sisl_orpol_type'(s_reg.or_setup[1:0]);
		if (i_pdm_mode) begin
			policy = sisl_pkg::OR_RAIL; // RULE21
		end
		rail = i_accel[15] ? `SISL_FULL_NEG : `SISL_FULL_POS;
		s_next.data_out = i_accel;
		if (!or_live) begin
			s_next.last_good = i_accel;
		end else if (!s_reg.or_setup[`SISL_OR_PROT_OFF]) begin // RULE19
			unique case (policy)
				sisl_pkg::OR_RAIL: s_next.data_out = rail; // RULE20
				sisl_pkg::OR_HOLD: s_next.data_out = s_reg.last_good; // RULE20
				default: s_next.data_out = i_accel; // RULE20
			endcase
		end

		// Sample ready: a new sample restarts the axis read tally
		// No axis enabled: the flag drops one cycle after it rises
		ax_seen = s_reg.axis_rd | ax_rd;
		if (i_sample_new) begin
			s_next.sample_ready = 1'b1; // RULE22
			s_next.axis_rd = 3'h0;
		end else if (s_reg.sample_ready
			&& (ax_seen & i_axis_en) == i_axis_en) begin
			s_next.sample_ready = 1'b0; // RULE5
			s_next.axis_rd = 3'h0;
		end else begin
			s_next.axis_rd = ax_seen;
		end

		// Read data, registered
		s_next.rdata = `SISL_RESET_BYTE;
		if (i_reg_rd) begin
			unique case (i_reg_addr)
				// Status bytes are built per read; spare bits read 0
				`SISL_ADDR_EVST0: s_next.rdata = s_reg.st0;
				`SISL_ADDR_EVST1: begin
					s_next.rdata[`SISL_ST1_NVM] = nvm_flag;
					s_next.rdata[`SISL_ST1_OR_STICKY] = s_reg.or_sticky;
					s_next.rdata[`SISL_ST1_OR_LIVE] = or_live;
				end
				`SISL_ADDR_EVST2: begin
					s_next.rdata[`SISL_ST2_ECC] = s_reg.ecc_det;
					s_next.rdata[`SISL_ST2_CRC] = s_reg.crc_err;
				end
				`SISL_ADDR_EVST3:
					s_next.rdata[`SISL_ST3_SMP_RDY] = s_reg.sample_ready;
				`SISL_ADDR_PARLIVE:
					s_next.rdata[`SISL_PARLIVE_BIT] = s_reg.par_live;
				`SISL_ADDR_PAREN: s_next.rdata[0] = s_reg.par_en;
				`SISL_ADDR_MAP_A_LO: s_next.rdata = s_reg.map_a[7:0];
				`SISL_ADDR_MAP_A_HI: s_next.rdata = s_reg.map_a[15:8];
				`SISL_ADDR_MAP_B_LO: s_next.rdata = s_reg.map_b[7:0];
				`SISL_ADDR_MAP_B_HI: s_next.rdata = s_reg.map_b[15:8];
				`SISL_ADDR_NVCHK: s_next.rdata = s_reg.nv_check_ctl;
				`SISL_ADDR_ORSET: s_next.rdata = s_reg.or_setup;
				default: ;
			endcase
		end

		// Interrupt sources, then per-pin OR of the mapped ones
		// Bits 13 to 15 stay spare and never raise a pin
		src = 16'h0000;
		src[0] = s_reg.sample_ready;
		src[1] = i_buf_ready; // RULE6
		src[2] = i_buf_overrun; // RULE6
		src[3] = s_reg.st0[`SISL_ST0_THRESH];
		src[4] = s_reg.st0[`SISL_ST0_ACT];
		src[5] = s_reg.st0[`SISL_ST0_INACT];
		src[6] = s_reg.st0[`SISL_ST0_UVOLT];
		src[7] = s_reg.st0[`SISL_ST0_PARITY]; // RULE13
		src[8] = s_reg.par_live; // RULE13
		src[9] = s_reg.st0[`SISL_ST0_WRBUSY];
		src[10] = nvm_flag;
		src[11] = or_live;
		src[12] = s_reg.or_sticky;
		s_next.pin_a = |(src & s_reg.map_a); // RULE1 RULE23
		s_next.pin_b = |(src & s_reg.map_b); // RULE1 RULE23

		if (!i_rst_n) begin
			s_next = '0;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		s_reg <= s_next;
	end

	// Push-pull drive only while mapped and out of reset
	assign o_irq_pin_a_oe = i_rst_n && |s_reg.map_a; // RULE2 RULE3 RULE8
	assign o_irq_pin_b_oe = i_rst_n && |s_reg.map_b; // RULE2 RULE3 RULE8
	assign o_irq_pin_a = s_reg.pin_a;
	assign o_irq_pin_b = s_reg.pin_b;
	assign o_reg_rdata = s_reg.rdata;
	assign o_accel_data = s_reg.data_out;
	// Copy of the check control byte for the memory controller
	assign o_nv_check_ctl = s_reg.nv_check_ctl;

endmodule : sisl_top

`default_nettype wire

// *** tb/sisl_top_properties.sv ***
// Port checker of sisl_top, bound to every instance of it.
// Assumes map and config writes are always taken.
`default_nettype none
module sisl_props (
	// Clock, reset and register port
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic [6:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [7:0] o_reg_rdata,
	// Event sources
	input wire logic i_buf_ready,
	input wire logic i_buf_overrun,
	input wire logic i_activity,
	input wire logic i_inactivity,
	input wire logic i_undervolt,
	input wire logic i_nvm_busy,
	input wire logic i_fuse_err,
	input wire logic i_ecc_det,
	input wire logic i_crc_err,
	// Data path and pins
	input wire logic signed [15:0] i_accel,
	input wire logic i_pdm_mode,
	input wire logic [15:0] o_accel_data,
	input wire logic o_irq_pin_a,
	input wire logic o_irq_pin_a_oe,
	input wire logic o_irq_pin_b,
	input wire logic o_irq_pin_b_oe
);
	logic [15:0] map_a_reg;
	logic [15:0] map_b_reg;
	logic [7:0] cfg_reg;
	logic over;
	logic rd11;
	logic rd12;
	logic quiet;
	// Shadow copies, since map and config are not visible at the ports
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			map_a_reg <= 16'h0000;
			map_b_reg <= 16'h0000;
			cfg_reg <= 8'h00;
		end else if (i_reg_wr) begin
			case (i_reg_addr)
				7'h2B: map_a_reg[7:0] <= i_reg_wdata;
				7'h2C: map_a_reg[15:8] <= i_reg_wdata;
				7'h2D: map_b_reg[7:0] <= i_reg_wdata;
				7'h2E: map_b_reg[15:8] <= i_reg_wdata;
				7'h48: cfg_reg <= i_reg_wdata;
				default: ;
			endcase
		end
	end
	assign over = !cfg_reg[3] &&
		(i_accel > 16'sh7F00 || i_accel < 16'sh8100);
	assign rd11 = i_reg_rd && i_reg_addr == 7'h11;
	assign rd12 = i_reg_rd && i_reg_addr == 7'h12;
	assign quiet = !i_activity && !i_inactivity && !i_undervolt &&
		!(i_reg_wr && i_nvm_busy);
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_n);
	// Must hold during reset itself, so no disable here
	property p_oe_rst;
		disable iff (1'b0) !i_rst_n |-> !o_irq_pin_a_oe && !o_irq_pin_b_oe;
	endproperty
	a_oe_rst: assert property (p_oe_rst) else $error("pin driven in reset");
	property p_oe_map;
		o_irq_pin_a_oe == (map_a_reg != 16'h0000) &&
		o_irq_pin_b_oe == (map_b_reg != 16'h0000);
	endproperty
	a_oe_map: assert property (p_oe_map) else $error("enable vs map");
	property p_pin_a;
		map_a_reg[1] && i_buf_ready |=> o_irq_pin_a;
	endproperty
	a_pin_a: assert property (p_pin_a) else $error("pin a not set");
	property p_pin_b;
		map_b_reg[2] && i_buf_overrun |=> o_irq_pin_b;
	endproperty
	a_pin_b: assert property (p_pin_b) else $error("pin b not set");
	property p_pin_low;
		map_a_reg == 16'h0002 && !i_buf_ready |=> !o_irq_pin_a;
	endproperty
	a_pin_low: assert property (p_pin_low) else $error("pin a not low");
	property p_busy;
		i_reg_wr && i_nvm_busy ##2 rd11 |=> o_reg_rdata[5];
	endproperty
	a_busy: assert property (p_busy) else $error("busy write lost");
	property p_st0_clr;
		rd11 && quiet ##1 quiet ##1 rd11 |=>
			o_reg_rdata[5:4] == 2'b00 && o_reg_rdata[2:1] == 2'b00;
	endproperty
	a_st0_clr: assert property (p_st0_clr) else $error("st0 not cleared");
	property p_st1_clr;
		rd12 && !over ##1 !over ##1 rd12 |=> !o_reg_rdata[4];
	endproperty
	a_st1_clr: assert property (p_st1_clr) else $error("st1 not cleared");
	property p_live;
		rd12 && over == $past(over) |=> o_reg_rdata[3] == $past(over);
	endproperty
	a_live: assert property (p_live) else $error("live flag wrong");
	property p_nvm;
		(i_fuse_err || i_ecc_det || i_crc_err) ##1 !i_reg_rd ##1 rd12
			|=> o_reg_rdata[7];
	endproperty
	a_nvm: assert property (p_nvm) else $error("memory flag lost");
	property p_rail;
		over && !cfg_reg[2] && (cfg_reg[1:0] == 2'b00 || i_pdm_mode) |=>
			o_accel_data == ($past(i_accel[15]) ? 16'h8000 : 16'h7FFF);
	endproperty
	a_rail: assert property (p_rail) else $error("data not railed");
	property p_pass;
		!over || cfg_reg[2] || (cfg_reg[1] && !i_pdm_mode) |=>
			o_accel_data == $past(i_accel);
	endproperty
	a_pass: assert property (p_pass) else $error("data altered");
	c_busy: cover property (i_reg_wr && i_nvm_busy);
	c_pdm: cover property (over && i_pdm_mode);
	c_pins: cover property (o_irq_pin_a && o_irq_pin_b);
endmodule : sisl_props
bind sisl_top sisl_props sisl_props_i (.i_sys_clk, .i_rst_n, .i_reg_addr,
	.i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .i_buf_ready,
	.i_buf_overrun, .i_activity, .i_inactivity, .i_undervolt, .i_nvm_busy,
	.i_fuse_err, .i_ecc_det, .i_crc_err, .i_accel, .i_pdm_mode,
	.o_accel_data, .o_irq_pin_a, .o_irq_pin_a_oe, .o_irq_pin_b,
	.o_irq_pin_b_oe);
`default_nettype wire

// *** tb/sisl_host_model.sv ***
// Host side of the two interrupt pins, with the pin bus keepers.
// Assumes the host reads the held level while a pin is undriven.
`default_nettype none
module sisl_host_model (
	// Pins from the device
	input wire logic i_pin_a,
	input wire logic i_oe_a,
	input wire logic i_pin_b,
	input wire logic i_oe_b,
	// Levels seen by the host
	output logic o_level_a,
	output logic o_level_b
);
	timeunit 1ns;
	timeprecision 1ps;
	always_latch begin
		if (i_oe_a) begin
			o_level_a = i_pin_a;
		end
	end
	always_latch begin
		if (i_oe_b) begin
			o_level_b = i_pin_b;
		end
	end
endmodule : sisl_host_model
`default_nettype wire

// *** tb/sensor_interrupt_status_logic_tb.sv ***
// Self-checking bench of sisl_top with the host pin model.
// Assumes a shortened parity tick and a single clock.
`default_nettype none
module sensor_interrupt_status_logic_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_sys_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [6:0] i_reg_addr = 7'h00;
	logic [7:0] i_reg_wdata = 8'h00;
	logic i_reg_wr = 1'b0;
	logic i_reg_rd = 1'b0;
	logic i_spi_mode = 1'b0;
	logic i_spi_cs_n = 1'b1;
	logic i_sample_new = 1'b0;
	logic [2:0] i_axis_en = 3'h0;
	logic i_buf_ready = 1'b0;
	logic i_buf_overrun = 1'b0;
	logic i_buf_above_thr = 1'b0;
	logic i_activity = 1'b0;
	logic i_inactivity = 1'b0;
	logic i_undervolt = 1'b0;
	logic i_nvm_busy = 1'b0;
	logic i_fuse_err = 1'b0;
	logic i_ecc_det = 1'b0;
	logic i_crc_err = 1'b0;
	logic signed [15:0] i_accel = 16'sh0000;
	logic i_pdm_mode = 1'b0;
	logic [7:0] o_reg_rdata;
	logic [15:0] o_accel_data;
	logic [7:0] o_nv_check_ctl;
	logic o_irq_pin_a, o_irq_pin_a_oe, o_irq_pin_b, o_irq_pin_b_oe;
	logic lvl_a, lvl_b;
	int mismatches = 0;
	int checks_done = 0;
	sisl_top #(.TICK_CYCLES(20)) sisl_top_i (.i_sys_clk, .i_rst_n,
		.i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata,
		.i_spi_mode, .i_spi_cs_n, .i_sample_new, .i_axis_en, .i_buf_ready,
		.i_buf_overrun, .i_buf_above_thr, .i_activity, .i_inactivity,
		.i_undervolt, .i_nvm_busy, .i_fuse_err, .i_ecc_det, .i_crc_err,
		.i_accel, .i_pdm_mode, .o_accel_data, .o_nv_check_ctl, .o_irq_pin_a,
		.o_irq_pin_a_oe, .o_irq_pin_b, .o_irq_pin_b_oe);
	sisl_host_model sisl_host_model_i (.i_pin_a(o_irq_pin_a),
		.i_oe_a(o_irq_pin_a_oe), .i_pin_b(o_irq_pin_b),
		.i_oe_b(o_irq_pin_b_oe), .o_level_a(lvl_a), .o_level_b(lvl_b));
	initial begin
		forever #5 i_sys_clk = ~i_sys_clk;
	end
	task automatic finish_test;
		if (mismatches == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : finish_test
	task automatic check(input string n, input logic [15:0] seen, exp);
		if (seen !== exp) begin
			$display("Error %s expected %h seen %h", n, exp, seen);
			mismatches++;
		end
		checks_done++;
	endtask : check
	task automatic cyc(input int n);
		repeat (n) @(negedge i_sys_clk);
	endtask : cyc
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(negedge i_sys_clk);
		i_reg_addr = a;
		i_reg_wdata = d;
		i_reg_wr = 1'b1;
		@(negedge i_sys_clk);
		i_reg_wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		@(negedge i_sys_clk);
		i_reg_addr = a;
		i_reg_rd = 1'b1;
		@(negedge i_sys_clk);
		d = o_reg_rdata;
		i_reg_rd = 1'b0;
	endtask : rd
	task automatic rdc(input logic [6:0] a, input logic [7:0] m, e,
		input string n);
		logic [7:0] d;
		rd(a, d);
		check(n, 16'(d & m), 16'(e));
	endtask : rdc
	task automatic evt(input int k);
		@(negedge i_sys_clk);
		{i_crc_err, i_ecc_det, i_fuse_err, i_undervolt, i_inactivity,
			i_activity} = 6'(1 << k);
		@(negedge i_sys_clk);
		{i_crc_err, i_ecc_det, i_fuse_err, i_undervolt, i_inactivity,
			i_activity} = 6'h00;
	endtask : evt
	task automatic acc(input logic [15:0] a, e, input string n);
		@(negedge i_sys_clk);
		i_accel = a;
		@(negedge i_sys_clk);
		check(n, o_accel_data, e);
	endtask : acc
	task automatic do_reset;
		i_rst_n = 1'b0;
		cyc(4);
		check("oe_a", 16'(o_irq_pin_a_oe), 16'h0000);
		check("oe_b", 16'(o_irq_pin_b_oe), 16'h0000);
		i_rst_n = 1'b1;
	endtask : do_reset
	task automatic t_regs;
		rdc(7'h29, 8'hFF, 8'h00, "ctl_rst");
		rdc(7'h48, 8'hFF, 8'h00, "cfg_rst");
		wr(7'h7F, 8'hFF);
		rdc(7'h7F, 8'hFF, 8'h00, "unmapped");
		wr(7'h29, 8'h5A);
		rdc(7'h29, 8'hFF, 8'h5A, "ctl_rw");
		check("ctl_out", 16'(o_nv_check_ctl), 16'h005A);
		check("oe_none", 16'(o_irq_pin_a_oe), 16'h0000);
	endtask : t_regs
	task automatic t_map;
		wr(7'h2B, 8'h02);
		wr(7'h2D, 8'h06);
		for (int k = 0; k < 4; k++) begin
			{i_buf_overrun, i_buf_ready} = 2'(k);
			cyc(2);
			check("pin_a", 16'(o_irq_pin_a), 16'(k[0]));
			check("pin_b", 16'(o_irq_pin_b), 16'(k != 0));
			check("oe", 16'({o_irq_pin_a_oe, o_irq_pin_b_oe}), 16'h3);
			check("lvl_b", 16'(lvl_b), 16'(k != 0));
		end
		wr(7'h2B, 8'h00);
		check("keep", 16'({o_irq_pin_a_oe, lvl_a}), 16'h1);
		{i_buf_overrun, i_buf_ready} = 2'h0;
		wr(7'h2D, 8'h00);
	endtask : t_map
	task automatic t_sticky;
		logic [7:0] m [3] = '{8'h02, 8'h04, 8'h10};
		for (int i = 0; i < 3; i++) begin
			evt(i);
			rdc(7'h11, 8'h16, m[i], "st0_set");
			rdc(7'h11, 8'h16, 8'h00, "st0_clr");
		end
		@(negedge i_sys_clk);
		i_reg_addr = 7'h11;
		i_reg_rd = 1'b1;
		i_activity = 1'b1;
		@(negedge i_sys_clk);
		i_reg_rd = 1'b0;
		i_activity = 1'b0;
		rdc(7'h11, 8'h02, 8'h02, "st0_race");
		i_nvm_busy = 1'b1;
		wr(7'h29, 8'h33);
		i_nvm_busy = 1'b0;
		rdc(7'h11, 8'h20, 8'h20, "wr_busy");
		rdc(7'h11, 8'h37, 8'h00, "busy_clr");
	endtask : t_sticky
	task automatic t_ready;
		logic [7:0] d;
		i_axis_en = 3'h5;
		@(negedge i_sys_clk);
		i_sample_new = 1'b1;
		@(negedge i_sys_clk);
		i_sample_new = 1'b0;
		rdc(7'h14, 8'h01, 8'h01, "rdy_set");
		rd(7'h15, d);
		rd(7'h16, d);
		rdc(7'h14, 8'h01, 8'h01, "rdy_part");
		rd(7'h19, d);
		rd(7'h1A, d);
		rdc(7'h14, 8'h01, 8'h00, "rdy_clr");
	endtask : t_ready
	task automatic t_thresh;
		i_spi_mode = 1'b1;
		i_spi_cs_n = 1'b0;
		i_buf_above_thr = 1'b1;
		rdc(7'h11, 8'h08, 8'h08, "thr_set");
		i_buf_above_thr = 1'b0;
		rdc(7'h11, 8'h08, 8'h08, "thr_rd");
		rdc(7'h11, 8'h08, 8'h08, "thr_cs");
		i_spi_cs_n = 1'b1;
		cyc(4);
		rdc(7'h11, 8'h08, 8'h00, "thr_clr");
		i_spi_mode = 1'b0;
	endtask : t_thresh
	task automatic t_nvm;
		evt(4);
		rdc(7'h13, 8'h28, 8'h20, "ecc");
		rdc(7'h12, 8'h80, 8'h00, "ecc_clr");
		evt(5);
		rdc(7'h12, 8'h80, 8'h80, "crc");
		rdc(7'h13, 8'h28, 8'h00, "crc_clr");
		evt(3);
		rdc(7'h12, 8'h80, 8'h80, "fuse");
		rdc(7'h12, 8'h80, 8'h00, "fuse_clr");
	endtask : t_nvm
	task automatic t_over;
		logic [7:0] d;
		// Maps are all clear here, so no pin reacts while settings change
		wr(7'h48, 8'h00);
		acc(16'h7FFF, 16'h7FFF, "rail_p");
		acc(16'h8010, 16'h8000, "rail_n");
		rdc(7'h12, 8'h18, 8'h18, "or_on");
		acc(16'h0000, 16'h0000, "or_end");
		rdc(7'h12, 8'h18, 8'h10, "or_st");
		rdc(7'h12, 8'h18, 8'h00, "or_clr");
		wr(7'h48, 8'h01);
		acc(16'h0100, 16'h0100, "hold0");
		acc(16'h7FFF, 16'h0100, "hold1");
		wr(7'h48, 8'h02);
		acc(16'h8010, 16'h8010, "pass");
		i_pdm_mode = 1'b1;
		acc(16'h8010, 16'h8000, "pdm");
		i_pdm_mode = 1'b0;
		wr(7'h48, 8'h04);
		acc(16'h7FF0, 16'h7FF0, "prot_off");
		rdc(7'h12, 8'h08, 8'h08, "det_on");
		wr(7'h48, 8'h08);
		acc(16'h8010, 16'h8010, "det_off");
		rd(7'h12, d);
		rdc(7'h12, 8'h18, 8'h00, "det_none");
		acc(16'h0000, 16'h0000, "zero");
		wr(7'h48, 8'h00);
	endtask : t_over
	task automatic t_parity;
		wr(7'h27, 8'h01);
		cyc(120);
		rdc(7'h20, 8'h20, 8'h00, "par_live");
		rdc(7'h11, 8'h01, 8'h00, "par_st");
		rdc(7'h27, 8'h01, 8'h01, "par_en");
		wr(7'h27, 8'h00);
	endtask : t_parity
	initial begin
		do_reset();
		t_regs();
		t_map();
		t_sticky();
		t_ready();
		t_thresh();
		t_nvm();
		t_over();
		t_parity();
		wr(7'h2B, 8'h02);
		do_reset();
		finish_test();
	end
	// Whole run is a few hundred cycles
	initial begin
		#50000;
		mismatches++;
		finish_test();
	end
endmodule : sensor_interrupt_status_logic_tb
`default_nettype wire
